// ===== design/asl_sequencer.sv
// abort and landing sequencer: landing chain, escape abort switchover,
// main_engine abort timing, apb register slave
// assumes crew switch and altitude contact inputs are clean and synchronous
//
// Operation
// - manual selector position suppresses all timed landing chain functions.
// - manual selector position blocks arming, landing controller never activates.
// - four manual commands fire apex, drogue deploy, drogue release, pilot chute.
// - command position inhibits propellant dump outputs of the low-altitude mode.
// - after switchover, escape separation drives thruster enable set coils.
// - escape abort below 30,000 ft after switchover uses timed landing chain.
// - escape abort 30,000 to 100,000 ft uses altitude contacts for every step.
// - engine abort accepted only between tower jettison and vehicle separation.
// - after tower jettison only manual request starts the engine abort.
// - engine abort start immediately fires settling thrust outputs.
// - settling thrust also inhibits pitch and yaw rate stabilization.
// - vehicle separation output asserts 3.0 s after engine abort start.
// - thruster enable arm asserts a further 0.8 s after separation.
// - apex cover jettison 0.4 s after landing controller activation.
// - drogue igniter 2.0 s after landing controller activation.
// - pilot chute and drogue release 14.0 s after activation.
`timescale 1ns/1ps
module asl_sequencer
  import asl_pkg::*;
#(
  parameter logic [31:0] SEP_CYCLES    = SEP_CYC,
  parameter logic [31:0] ARM_CYCLES    = ARM_CYC,
  parameter logic [31:0] APEX_CYCLES   = APEX_CYC,
  parameter logic [31:0] DROGUE_CYCLES = DROGUE_CYC,
  parameter logic [31:0] PILOT_CYCLES  = PILOT_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // crew switches and altitude contacts
  input  wire logic        manual_abort_req,
  input  wire logic        auto_abort_detect,
  input  wire logic        tower_jettisoned,
  input  wire logic        vehicle_separated,
  input  wire logic        baro_upper,
  input  wire logic        baro_lower,
  input  wire logic        high_alt_abort,
  // relay and pyro commands
  output asl_cmd_t         cmd,
  output logic             landing_sequence_ctl
);

  // ==========================================================
  // apb decode
  logic [2:0]  ctrl;
  logic [31:0] b_cnt;
  logic [31:0] l_cnt;
  logic        esc_active;
  logic        esc_high;
  logic        esc_lowmode;
  asl_bstate_t b_state;

  wire acc       = psel & penable & pready;
  wire wr        = acc & pwrite;
  wire hit_ctrl  = (paddr == OFF_CTRL);
  wire hit_man   = (paddr == OFF_MANCMD);
  wire hit_stat  = (paddr == OFF_STATUS);
  wire mapped    = hit_ctrl | hit_man | hit_stat;
  wire wr_ctrl   = wr & hit_ctrl;
  wire wr_man    = wr & hit_man;
  wire sclear    = wr_ctrl & pwdata[CTRL_CLEAR];
  wire manual    = ctrl[CTRL_MANUAL];
  wire cmd_pos   = ctrl[CTRL_CMDPOS];
  wire [3:0] manual_override_pos = wr_man ? pwdata[3:0] : 4'h0;

  wire [31:0] stat_word = {17'h0, b_state, esc_high, esc_active, landing_sequence_ctl, cmd};
  wire [31:0] rd_word   = hit_ctrl ? {29'h0, ctrl} :
                          hit_stat ? stat_word : 32'h0;

  // one wait state; pready and read data both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_word : 32'h0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[2:0];
    end
  end

  // ==========================================================
  // escape abort and switchover
  // auto detection only counts while the tower is still on
  wire esc_start = (manual_abort_req | auto_abort_detect) & ~tower_jettisoned & ~esc_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_active  <= 1'b0;
      esc_high    <= 1'b0;
      esc_lowmode <= 1'b0;
    end else if (sclear) begin
      esc_active  <= 1'b0;
      esc_high    <= 1'b0;
      esc_lowmode <= 1'b0;
    end else if (esc_start) begin
      esc_active  <= 1'b1;
      esc_high    <= high_alt_abort;
      esc_lowmode <= ~cmd_pos;
    end
  end

  // ==========================================================
  // main_engine abort sequence
  wire b_window = tower_jettisoned & ~vehicle_separated;
  wire b_start  = manual_abort_req & b_window & (b_state == B_IDLE);

  asl_bstate_t next_b_state;
  always_comb begin
    next_b_state = b_state;
    unique case (b_state)
      B_IDLE:    if (b_start) next_b_state = B_SETTLE;
      B_SETTLE:  if (b_cnt >= SEP_CYCLES - 32'd1) next_b_state = B_ARMWAIT;
      B_ARMWAIT: if (b_cnt >= SEP_CYCLES + ARM_CYCLES - 32'd1) next_b_state = B_DONE;
      B_DONE:    next_b_state = B_DONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_state <= B_IDLE;
      b_cnt   <= 32'h0;
    end else if (sclear) begin
      b_state <= B_IDLE;
      b_cnt   <= 32'h0;
    end else begin
      b_state <= next_b_state;
      // counts edges spent in the timed states, so the start edge itself is not counted
      b_cnt   <= (b_state == B_SETTLE || b_state == B_ARMWAIT) ? b_cnt + 32'd1 : b_cnt;
    end
  end

  // ==========================================================
  // landing sequence controller
  wire land_go    = ctrl[CTRL_ARM] & ~manual & baro_upper & ~landing_sequence_ctl;
  wire timed_mode = ~esc_high;
  wire l_run      = landing_sequence_ctl & ~manual & timed_mode & (l_cnt < PILOT_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      landing_sequence_ctl <= 1'b0;
      l_cnt                <= 32'h0;
    end else if (sclear) begin
      landing_sequence_ctl <= 1'b0;
      l_cnt                <= 32'h0;
    end else begin
      landing_sequence_ctl <= landing_sequence_ctl | land_go;
      l_cnt                <= l_run ? l_cnt + 32'd1 : l_cnt;
    end
  end

  // timed chain or altitude contacts, each gated off in manual
  wire auto_ok     = landing_sequence_ctl & ~manual;
  wire t_apex      = auto_ok & (timed_mode ? (l_cnt >= APEX_CYCLES) : baro_upper);
  wire t_drogue    = auto_ok & (timed_mode ? (l_cnt >= DROGUE_CYCLES) : baro_upper);
  wire t_pilot     = auto_ok & (timed_mode ? (l_cnt >= PILOT_CYCLES) : baro_lower);

  // ==========================================================
  // command outputs, all registered; settling thrust, rate inhibit, separation, arm and dump follow state, the rest latch
  asl_cmd_t next_cmd;
  always_comb begin
    next_cmd                        = cmd;
    next_cmd.apex_jettison          = cmd.apex_jettison | t_apex | manual_override_pos[MAN_APEX];
    next_cmd.drogue_deploy          = cmd.drogue_deploy | t_drogue | manual_override_pos[MAN_DROGUE];
    next_cmd.drogue_release         = cmd.drogue_release | t_pilot | manual_override_pos[MAN_RELEASE];
    next_cmd.pilot_deploy           = cmd.pilot_deploy | t_pilot | manual_override_pos[MAN_PILOT];
    next_cmd.prop_dump              = esc_active & esc_lowmode & ~cmd_pos;
    next_cmd.thruster_enable_set    = cmd.thruster_enable_set | (esc_active & cmd_pos);
    next_cmd.settling_thrust_out    = (next_b_state == B_SETTLE);
    next_cmd.rate_stab_inhibit      = (next_b_state == B_SETTLE);
    next_cmd.vehicle_separation_out = (next_b_state == B_ARMWAIT) | (next_b_state == B_DONE);
    next_cmd.thruster_enable_arm    = (next_b_state == B_DONE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (sclear) begin
      cmd <= '0;
    end else begin
      cmd <= next_cmd;
    end
  end

  // ==========================================================
  // checks
  sequence s_engine_start;
    b_start && !sclear;
  endsequence

  sequence s_settle_on;
    cmd.settling_thrust_out && cmd.rate_stab_inhibit;
  endsequence

  a_settle_immediate: assert property (@(posedge pclk) disable iff (!presetn)
    s_engine_start |=> s_settle_on)
    else $error("settling thrust not fired on engine abort start");

  a_stab_inhibit_tie: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.settling_thrust_out == cmd.rate_stab_inhibit)
    else $error("rate inhibit differs from settling thrust");

  a_sep_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.vehicle_separation_out) |-> (b_cnt == SEP_CYCLES))
    else $error("vehicle separation at wrong delay");

  a_arm_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.thruster_enable_arm) |-> (b_cnt == SEP_CYCLES + ARM_CYCLES) && $past(cmd.vehicle_separation_out))
    else $error("thruster arm at wrong delay");

  a_auto_after_tower: assert property (@(posedge pclk) disable iff (!presetn)
    (b_state == B_IDLE) && tower_jettisoned && auto_abort_detect && !manual_abort_req |=> (b_state == B_IDLE))
    else $error("auto detect started engine abort");

  a_window_only: assert property (@(posedge pclk) disable iff (!presetn)
    (b_state == B_IDLE) && !(tower_jettisoned && !vehicle_separated) |=> (b_state == B_IDLE))
    else $error("engine abort outside its window");

  a_manual_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    manual && !landing_sequence_ctl |=> !landing_sequence_ctl)
    else $error("landing controller activated in manual");

  a_manual_no_timer: assert property (@(posedge pclk) disable iff (!presetn)
    manual && !manual_override_pos[MAN_APEX] && !cmd.apex_jettison && !sclear |=> !cmd.apex_jettison)
    else $error("timed apex fired in manual");

  a_apex_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.apex_jettison) && timed_mode && !$past(wr_man) |-> ($past(l_cnt) >= APEX_CYCLES))
    else $error("apex jettison before delay");

  a_pilot_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.pilot_deploy) && timed_mode && !$past(wr_man) |-> ($past(l_cnt) >= PILOT_CYCLES))
    else $error("pilot chute before delay");

  a_manual_fire: assert property (@(posedge pclk) disable iff (!presetn)
    wr_man && pwdata[MAN_DROGUE] |=> cmd.drogue_deploy)
    else $error("manual drogue command not fired");

  a_dump_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_pos |=> !cmd.prop_dump)
    else $error("propellant dump in command position");

  a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    sclear |=> (cmd == '0) && (b_cnt == 32'h0) && (l_cnt == 32'h0))
    else $error("synchronous clear left state behind");

  // ==========================================================
  // further checks on the timed chains and the abort modes
  sequence s_high_upper;
    landing_sequence_ctl && !manual && esc_high && baro_upper && !sclear;
  endsequence

  sequence s_high_lower;
    landing_sequence_ctl && !manual && esc_high && baro_lower && !sclear;
  endsequence

  sequence s_low_apex_due;
    landing_sequence_ctl && !manual && !esc_high && (l_cnt >= APEX_CYCLES) && !sclear;
  endsequence

  a_drogue_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.drogue_deploy) && timed_mode && !$past(wr_man) |-> ($past(l_cnt) >= DROGUE_CYCLES))
    else $error("drogue deploy before delay");

  a_release_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.drogue_release) && timed_mode && !$past(wr_man) |-> ($past(l_cnt) >= PILOT_CYCLES))
    else $error("drogue release before delay");

  a_sep_latches: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.vehicle_separation_out && !sclear |=> cmd.vehicle_separation_out)
    else $error("vehicle separation dropped");

  a_arm_after_sep: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.thruster_enable_arm |-> cmd.vehicle_separation_out)
    else $error("thruster arm without separation");

  a_settle_ends: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.settling_thrust_out |-> !cmd.vehicle_separation_out)
    else $error("settling thrust still on after separation");

  a_enable_set: assert property (@(posedge pclk) disable iff (!presetn)
    esc_active && cmd_pos && !sclear |=> cmd.thruster_enable_set)
    else $error("thruster enable set coil not driven");

  a_high_upper: assert property (@(posedge pclk) disable iff (!presetn)
    s_high_upper |=> cmd.apex_jettison && cmd.drogue_deploy)
    else $error("upper contact did not fire apex and drogue");

  a_high_lower: assert property (@(posedge pclk) disable iff (!presetn)
    s_high_lower |=> cmd.pilot_deploy && cmd.drogue_release)
    else $error("lower contact did not fire pilot and release");

  a_low_timed: assert property (@(posedge pclk) disable iff (!presetn)
    s_low_apex_due |=> cmd.apex_jettison)
    else $error("timed apex missing in low mode");

  a_manual_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    manual && !sclear |=> (l_cnt == $past(l_cnt)))
    else $error("landing timer ran in manual");

  a_dump_lowmode: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.prop_dump |-> !$past(cmd_pos))
    else $error("propellant dump driven from command position");

  a_abort_window: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.settling_thrust_out) |-> $past(tower_jettisoned && !vehicle_separated))
    else $error("engine abort started outside window");

  a_manual_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmd.settling_thrust_out) |-> $past(manual_abort_req))
    else $error("engine abort started without crew request");

  a_clear_state: assert property (@(posedge pclk) disable iff (!presetn)
    sclear |=> !landing_sequence_ctl && (b_state == B_IDLE) && !esc_active)
    else $error("synchronous clear left sequencers running");

  // one wait state means pready can never stand two cycles
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held for more than one cycle");

endmodule

// ===== design/asl_pkg.sv
// abort and landing sequencer: shared constants and types
// assumes one 125 MHz clock; register map sits on an apb slave
package asl_pkg;

  // ==========================================================
  // clock and delays
  localparam longint unsigned CLK_HZ        = 64'd125_000_000;
  localparam longint unsigned T_SEP_MS      = 64'd3000;
  localparam longint unsigned T_ARM_MS      = 64'd800;
  localparam longint unsigned T_APEX_MS     = 64'd400;
  localparam longint unsigned T_DROGUE_MS   = 64'd2000;
  localparam longint unsigned T_PILOT_MS    = 64'd14000;
  localparam logic [31:0] SEP_CYC    = 32'(T_SEP_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] ARM_CYC    = 32'(T_ARM_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] APEX_CYC   = 32'(T_APEX_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] DROGUE_CYC = 32'(T_DROGUE_MS * CLK_HZ / 64'd1000);
  localparam logic [31:0] PILOT_CYC  = 32'(T_PILOT_MS * CLK_HZ / 64'd1000);

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MANCMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // control fields
  localparam int CTRL_MANUAL = 0;
  localparam int CTRL_CMDPOS = 1;
  localparam int CTRL_ARM    = 2;
  localparam int CTRL_CLEAR  = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // manual command fields (write one to fire)
  localparam int MAN_APEX    = 0;
  localparam int MAN_DROGUE  = 1;
  localparam int MAN_RELEASE = 2;
  localparam int MAN_PILOT   = 3;

  // ==========================================================
  // relay and pyro command word
  typedef struct packed {
    logic apex_jettison;
    logic drogue_deploy;
    logic drogue_release;
    logic pilot_deploy;
    logic prop_dump;
    logic thruster_enable_set;
    logic settling_thrust_out;
    logic rate_stab_inhibit;
    logic vehicle_separation_out;
    logic thruster_enable_arm;
  } asl_cmd_t;

  typedef enum logic [1:0] { B_IDLE, B_SETTLE, B_ARMWAIT, B_DONE } asl_bstate_t;

endpackage

// ===== tb/asl_crew_model.sv
// crew switch and altitude contact model for the sequencer bench
// assumes the bench hands it a switch word changed just after pclk edges
`timescale 1ns/1ps
module asl_crew_model (
  // switch word: abort, auto, tower, separated, upper, lower, high
  input  wire logic [6:0] sw,
  // contacts toward the sequencer
  output logic            manual_abort_req,
  output logic            auto_abort_detect,
  output logic            tower_jettisoned,
  output logic            vehicle_separated,
  output logic            baro_upper,
  output logic            baro_lower,
  output logic            high_alt_abort
);
  // contacts are plain levels, so no hold or release pattern applies
  assign {manual_abort_req, auto_abort_detect, tower_jettisoned, vehicle_separated,
          baro_upper, baro_lower, high_alt_abort} = sw;
endmodule

// ===== tb/tb.sv
// self-checking bench for the abort and landing sequencer
// assumes short delay parameters and the apb map of the package
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import asl_pkg::*;
  localparam int SEP = 30, ARM = 8, APX = 4, DRG = 20, PIL = 140;
  // ==========================================================
  // signals
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er;
  logic [6:0]  sw = 7'h00;
  logic        mab, aad, twj, vsp, bup, blo, hia, lsc;
  asl_cmd_t    cmd;
  wire logic [10:0] obs = {lsc, cmd};
  int          n_errors = 0, n_tests = 0, n;
  always #4 pclk = ~pclk;
  asl_crew_model crew_u (.sw(sw), .manual_abort_req(mab), .auto_abort_detect(aad),
    .tower_jettisoned(twj), .vehicle_separated(vsp), .baro_upper(bup),
    .baro_lower(blo), .high_alt_abort(hia));
  asl_sequencer #(.SEP_CYCLES(SEP), .ARM_CYCLES(ARM), .APEX_CYCLES(APX),
    .DROGUE_CYCLES(DRG), .PILOT_CYCLES(PIL)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .manual_abort_req(mab),
    .auto_abort_detect(aad), .tower_jettisoned(twj), .vehicle_separated(vsp),
    .baro_upper(bup), .baro_lower(blo), .high_alt_abort(hia), .cmd(cmd),
    .landing_sequence_ctl(lsc));
  // ==========================================================
  // shared tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ends when pready is seen high; no limit of its own, the watchdog bounds it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // counts edges until an observed output is seen high
  task automatic wait_hi(input int idx, input int lim);
    n = 0;
    while (obs[idx] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic sync_clear(input logic [2:0] ctrl);
    sw <= 7'h00;
    apb(1'b1, OFF_CTRL, {28'h0, 1'b1, ctrl});
    idle(2);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 8'h0c, 32'hf);
    `CHK(er, 1'b1)
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK(rd[2:0], CTRL_RESET)
  endtask
  task automatic t_engine;
    sw <= 7'h58;
    idle(4);
    `CHK(obs[3], 1'b0)
    sw <= 7'h30;
    idle(4);
    `CHK(obs[3], 1'b0)
    sw <= 7'h70;
    wait_hi(3, 10);
    `CHK(n, 2)
    `CHK(obs[2], 1'b1)
    wait_hi(1, 100);
    `CHK(n, SEP)
    `CHK(obs[3], 1'b0)
    wait_hi(0, 100);
    `CHK(n, ARM)
    sync_clear(3'h0);
    `CHK(obs, 11'h0)
  endtask
  task automatic t_landing;
    sw <= 7'h04;
    apb(1'b1, OFF_CTRL, 32'h4);
    wait_hi(10, 20);
    wait_hi(9, 50);
    `CHK(n, APX + 1)
    wait_hi(8, 100);
    `CHK(n, DRG - APX)
    wait_hi(6, 300);
    `CHK(n, PIL - DRG)
    `CHK(obs[7], 1'b1)
    sync_clear(3'h0);
  endtask
  task automatic t_manual;
    sw <= 7'h04;
    apb(1'b1, OFF_CTRL, 32'h5);
    idle(DRG + 4);
    `CHK(obs[10], 1'b0)
    `CHK(obs[9:8], 2'b00)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_MANCMD, 32'h1 << i);
      idle(1);
      `CHK(obs[9 - i], 1'b1)
    end
    sync_clear(3'h0);
  endtask
  task automatic t_switch;
    sync_clear(3'h2);
    sw <= 7'h40;
    idle(4);
    `CHK(obs[5], 1'b0)
    `CHK(obs[4], 1'b1)
    sw <= 7'h44;
    apb(1'b1, OFF_CTRL, 32'h6);
    wait_hi(9, 50);
    `CHK(n, APX + 3)
    sync_clear(3'h0);
    sw <= 7'h40;
    idle(4);
    `CHK(obs[5], 1'b1)
    sync_clear(3'h0);
  endtask
  task automatic t_high;
    sw <= 7'h41;
    idle(3);
    sw <= 7'h04;
    apb(1'b1, OFF_CTRL, 32'h4);
    idle(4);
    `CHK(obs[9:8], 2'b11)
    `CHK(obs[6], 1'b0)
    sw <= 7'h06;
    idle(3);
    `CHK(obs[7:6], 2'b11)
    sync_clear(3'h0);
  endtask
  // ==========================================================
  // run control
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_engine();
    t_landing();
    t_manual();
    t_switch();
    t_high();
    complete_run();
  end
  // whole run needs well under 2000 cycles
  initial begin
    #100us;
    n_errors++;
    complete_run();
  end
endmodule
